// file: common/bcs_map.svh
// Contract
// - Hall CBA 101..100 map to states 0..5, each with one PWM, one low, one off phase
// - Commutation offset is added to the Hall-derived state before pattern selection
// - Phases switch at the configured PWM rate; sensorless step runs once per PWM period
// - Hardware over-current protection can be enabled or disabled
// - Over-current status clears after the configured millisecond time
// - A clear time of zero never clears over-current; only reset restores drive
// - Speed measurement is scaled by the configured pole pair count
// - Rated speed only normalises reported speed, never the phase drive
// - Sensorless position comes from back-EMF on the undriven phase while rotating
// - Sensorless startup runs ramp-up without rotation feedback, then normal operation
// - During ramp-up states advance on a timer regardless of back-EMF
// - Ramp-up starts with the initial step length, counted in PWM ticks
// - Ramp-up ends when the interval has reached the final step length
// - Each expiry of the acceleration delay shortens the interval by one tick
// - Ramp duration is (initial minus final) times acceleration over tick rate
// - After ramp-up, back-EMF position steers the phase pattern
// - Duty comes from speed, current, or both controllers as configured
// - With Hall A pickup selected, speed is measured from Hall A edges
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
`define BCS_CLK_NS        10
`define BCS_MS_NS         1000000
`define BCS_OFF_CTRL      8'h00
`define BCS_OFF_OFFSET    8'h04
`define BCS_OFF_PWMDIV    8'h08
`define BCS_OFF_OCCLR     8'h0C
`define BCS_OFF_POLES     8'h10
`define BCS_OFF_RATED     8'h14
`define BCS_OFF_RINIT     8'h18
`define BCS_OFF_RFINAL    8'h1C
`define BCS_OFF_RACC      8'h20
`define BCS_OFF_STATUS    8'h24
`define BCS_OFF_PERIOD    8'h28
`define BCS_OFF_NORM      8'h2C
`define BCS_CTRL_EN       0
`define BCS_CTRL_SLESS    1
`define BCS_CTRL_OCP      2
`define BCS_CTRL_HALLA    3
`define BCS_CTRL_DSEL     5:4
`define BCS_DSEL_SPEED    2'h0
`define BCS_DSEL_CURR     2'h1
`define BCS_RST_CTRL      6'h04
`define BCS_RST_PWMDIV    16'h2710
`define BCS_RST_OCCLR     16'h0064
`define BCS_RST_POLES     8'h04
`define BCS_RST_RATED     16'h0BB8
`define BCS_RST_RINIT     16'h0064
`define BCS_RST_RFINAL    16'h0028
`define BCS_RST_RACC      16'h0064
`define BCS_ST_NONE       3'h7
`endif

// file: common/bcs_pkg.sv
package bcs_pkg;
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } bcs_phase_t;
  typedef enum logic [1:0] {
    BCS_IDLE,
    BCS_RAMP,
    BCS_RUN
  } bcs_mode_t;
endpackage

// file: hw/bcs_commutation.sv
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"
module bcs_commutation #(
  parameter int unsigned CLK_PER_MS = `BCS_MS_NS / `BCS_CLK_NS
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output var  logic               hreadyout,
  output var  logic [31:0]        hrdata,
  output var  logic               hresp,
  input  wire logic [2:0]         hall,
  input  wire logic [2:0]         bemf,
  input  wire logic               ocFault,
  input  wire logic [7:0]         spdDuty,
  input  wire logic [7:0]         curDuty,
  output var  bcs_pkg::bcs_phase_t phaseDrive,
  output var  logic [23:0]        speedPeriod,
  output var  logic [31:0]        speedNorm
);
  import bcs_pkg::*;

  logic [2:0]  hallS1;
  logic [2:0]  hallS2;
  logic [2:0]  bemfS1;
  logic [2:0]  bemfS2;
  logic        ocS1;
  logic        ocS2;
  logic        accept;
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [31:0] rdData;
  logic [5:0]  ctrlReg;
  logic [2:0]  offsetReg;
  logic [15:0] pwmDiv;
  logic [15:0] ocClrMs;
  logic [7:0]  polePairs;
  logic [15:0] ratedRpm;
  logic [15:0] rampInit;
  logic [15:0] rampFinal;
  logic [15:0] rampAcc;
  logic [15:0] pwmCnt;
  logic        tick;
  logic [7:0]  dutyNow;
  logic [23:0] dutyLim;
  logic        pwmOn;
  logic        ocActive;
  logic [31:0] msCnt;
  logic [15:0] msElapsed;
  bcs_mode_t   mode;
  logic [15:0] interval;
  logic [15:0] stepCnt;
  logic [15:0] accCnt;
  logic [2:0]  slState;
  logic [2:0]  bemfLast;
  logic [1:0]  floatIdx;
  logic        bemfEdge;
  logic [2:0]  hallState;
  logic [2:0]  actState;
  logic [2:0]  prevState;
  logic        hallAPrev;
  logic        pickup;
  logic [15:0] periodCnt;
  logic [15:0] elecPeriod;

  wire logic enable    = ctrlReg[`BCS_CTRL_EN];
  wire logic sensorless = ctrlReg[`BCS_CTRL_SLESS];
  wire logic ocpEnable = ctrlReg[`BCS_CTRL_OCP];
  wire logic useHallA  = ctrlReg[`BCS_CTRL_HALLA];

  function automatic logic [2:0] hallToState(input logic [2:0] h);
    unique case (h)
      3'b101:  hallToState = 3'h0;
      3'b001:  hallToState = 3'h1;
      3'b011:  hallToState = 3'h2;
      3'b010:  hallToState = 3'h3;
      3'b110:  hallToState = 3'h4;
      3'b100:  hallToState = 3'h5;
      default: hallToState = `BCS_ST_NONE;
    endcase
  endfunction

  function automatic logic [2:0] addMod6(input logic [2:0] s, input logic [2:0] off);
    addMod6 = 3'(({1'b0, s} + {1'b0, off}) % 4'h6);
  endfunction
  // Phase index 0 = A, 1 = B, 2 = C
  function automatic logic [1:0] commHi(input logic [2:0] s);
    unique case (s)
      3'h0, 3'h1: commHi = 2'h0;
      3'h2, 3'h3: commHi = 2'h1;
      default:    commHi = 2'h2;
    endcase
  endfunction

  function automatic logic [1:0] commLo(input logic [2:0] s);
    unique case (s)
      3'h0, 3'h5: commLo = 2'h1;
      3'h1, 3'h2: commLo = 2'h2;
      default:    commLo = 2'h0;
    endcase
  endfunction

  // Pins come from outside the clock domain
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {ocS1, bemfS1, hallS1} <= 7'h00;
      {ocS2, bemfS2, hallS2} <= 7'h00;
    end else begin
      {ocS1, bemfS1, hallS1} <= {ocFault, bemf, hall};
      {ocS2, bemfS2, hallS2} <= {ocS1, bemfS1, hallS1};
    end
  end
  // AHB-Lite slave: zero wait states, always OKAY
  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    unique case (haddr[7:0])
      `BCS_OFF_CTRL:   rdData = {26'h0, ctrlReg};
      `BCS_OFF_OFFSET: rdData = {29'h0, offsetReg};
      `BCS_OFF_PWMDIV: rdData = {16'h0, pwmDiv};
      `BCS_OFF_OCCLR:  rdData = {16'h0, ocClrMs};
      `BCS_OFF_POLES:  rdData = {24'h0, polePairs};
      `BCS_OFF_RATED:  rdData = {16'h0, ratedRpm};
      `BCS_OFF_RINIT:  rdData = {16'h0, rampInit};
      `BCS_OFF_RFINAL: rdData = {16'h0, rampFinal};
      `BCS_OFF_RACC:   rdData = {16'h0, rampAcc};
      `BCS_OFF_STATUS: rdData = {10'h0, interval, mode, ocActive, actState};
      `BCS_OFF_PERIOD: rdData = {8'h0, speedPeriod};
      `BCS_OFF_NORM:   rdData = speedNorm;
      default:         rdData = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend    <= accept && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (accept) begin
        wrAddr <= haddr[7:0];
      end
      // Read data is captured in the address phase, so it reflects state before a
      // write whose data phase overlaps it
      if (accept && !hwrite) begin
        hrdata <= rdData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrlReg   <= `BCS_RST_CTRL;
      offsetReg <= 3'h0;
      pwmDiv    <= `BCS_RST_PWMDIV;
      ocClrMs   <= `BCS_RST_OCCLR;
      polePairs <= `BCS_RST_POLES;
      ratedRpm  <= `BCS_RST_RATED;
      rampInit  <= `BCS_RST_RINIT;
      rampFinal <= `BCS_RST_RFINAL;
      rampAcc   <= `BCS_RST_RACC;
    end else if (wrPend) begin
      unique case (wrAddr)
        `BCS_OFF_CTRL:   ctrlReg   <= hwdata[5:0];
        `BCS_OFF_OFFSET: offsetReg <= hwdata[2:0];
        `BCS_OFF_PWMDIV: pwmDiv    <= hwdata[15:0];
        `BCS_OFF_OCCLR:  ocClrMs   <= hwdata[15:0];
        `BCS_OFF_POLES:  polePairs <= hwdata[7:0];
        `BCS_OFF_RATED:  ratedRpm  <= hwdata[15:0];
        `BCS_OFF_RINIT:  rampInit  <= hwdata[15:0];
        `BCS_OFF_RFINAL: rampFinal <= hwdata[15:0];
        `BCS_OFF_RACC:   rampAcc   <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // PWM carrier; its wrap is the commutation tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwmCnt <= 16'h0000;
      tick   <= 1'b0;
    end else if (pwmCnt >= pwmDiv - 16'h0001) begin
      pwmCnt <= 16'h0000;
      tick   <= 1'b1;
    end else begin
      pwmCnt <= pwmCnt + 16'h0001;
      tick   <= 1'b0;
    end
  end

  always_comb begin
    unique case (ctrlReg[`BCS_CTRL_DSEL])
      `BCS_DSEL_SPEED: dutyNow = spdDuty;
      `BCS_DSEL_CURR:  dutyNow = curDuty;
      default:         dutyNow = (spdDuty < curDuty) ? spdDuty : curDuty;
    endcase
  end

  assign dutyLim = {8'h00, pwmDiv} * {16'h0000, dutyNow};
  assign pwmOn   = {pwmCnt, 8'h00} < dutyLim;

  // A fault still present keeps restarting the clear timer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ocActive  <= 1'b0;
      msCnt     <= 32'h0;
      msElapsed <= 16'h0000;
    end else if (ocpEnable && ocS2) begin
      ocActive  <= 1'b1;
      msCnt     <= 32'h0;
      msElapsed <= 16'h0000;
    end else if (ocActive && ocClrMs != 16'h0000) begin
      if (msCnt >= 32'(CLK_PER_MS - 1)) begin
        msCnt <= 32'h0;
        if (msElapsed + 16'h0001 >= ocClrMs) begin
          ocActive  <= 1'b0;
          msElapsed <= 16'h0000;
        end else begin
          msElapsed <= msElapsed + 16'h0001;
        end
      end else begin
        msCnt <= msCnt + 32'h1;
      end
    end
  end

  // Sensorless startup; ramp-up time is (init - final) * acc PWM periods
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode     <= BCS_IDLE;
      interval <= `BCS_RST_RINIT;
      stepCnt  <= 16'h0000;
      accCnt   <= 16'h0000;
      slState  <= 3'h0;
    end else if (!enable || !sensorless || ocActive) begin
      mode <= BCS_IDLE;
    end else begin
      unique case (mode)
        BCS_IDLE: begin
          mode     <= BCS_RAMP;
          interval <= rampInit;
          stepCnt  <= 16'h0000;
          accCnt   <= 16'h0000;
          slState  <= 3'h0;
        end
        BCS_RAMP: begin
          if (tick) begin
            if (stepCnt + 16'h0001 >= interval) begin
              stepCnt <= 16'h0000;
              slState <= addMod6(slState, 3'h1);
            end else begin
              stepCnt <= stepCnt + 16'h0001;
            end
            if (accCnt + 16'h0001 >= rampAcc) begin
              accCnt <= 16'h0000;
              if (interval > rampFinal) begin
                interval <= interval - 16'h0001;
              end
            end else begin
              accCnt <= accCnt + 16'h0001;
            end
            if (interval <= rampFinal) begin
              mode <= BCS_RUN;
            end
          end
        end
        BCS_RUN: begin
          if (tick && bemfEdge) begin
            slState <= addMod6(slState, 3'h1);
          end
        end
      endcase
    end
  end

  // Comparators are judged once per PWM period, on the phase left floating
  assign floatIdx = 2'h3 - commHi(slState) - commLo(slState);
  assign bemfEdge = bemfS2[floatIdx] != bemfLast[floatIdx];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bemfLast <= 3'h0;
    end else if (tick) begin
      bemfLast <= bemfS2;
    end
  end

  assign hallState = (hallToState(hallS2) == `BCS_ST_NONE) ? `BCS_ST_NONE
                   : addMod6(hallToState(hallS2), offsetReg);
  assign actState  = sensorless ? ((mode == BCS_IDLE) ? `BCS_ST_NONE : slState)
                   : hallState;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phaseDrive <= '0;
    end else if (!enable || ocActive || actState == `BCS_ST_NONE) begin
      phaseDrive <= '0;
    end else begin
      phaseDrive.hi <= pwmOn ? (3'h1 << commHi(actState)) : 3'h0;
      phaseDrive.lo <= 3'h1 << commLo(actState);
    end
  end

  // Speed pickup: ticks per electrical turn
  assign pickup = useHallA ? (hallS2[0] && !hallAPrev)
                : (actState == 3'h0 && prevState != 3'h0);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hallAPrev  <= 1'b0;
      prevState  <= `BCS_ST_NONE;
      periodCnt  <= 16'h0000;
      elecPeriod <= 16'h0000;
    end else begin
      hallAPrev <= hallS2[0];
      prevState <= actState;
      if (pickup) begin
        elecPeriod <= periodCnt;
        periodCnt  <= 16'h0000;
      end else if (tick && periodCnt != 16'hFFFF) begin
        periodCnt <= periodCnt + 16'h0001;
      end
    end
  end

  // Rated speed only scales the reported figure, never the drive
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      speedPeriod <= 24'h0;
      speedNorm   <= 32'h0;
    end else begin
      speedPeriod <= {8'h00, elecPeriod} * {16'h0000, polePairs};
      speedNorm   <= 32'(({16'h0000, speedPeriod} * {24'h0, ratedRpm}) >> 8);
    end
  end

  logic [15:0] sinceTick;
  logic        seenTick;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sinceTick <= 16'h0000;
      seenTick  <= 1'b0;
    end else begin
      sinceTick <= tick ? 16'h0001 : sinceTick + 16'h0001;
      seenTick  <= seenTick || tick;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_HALL_MAP: assert property (!sensorless && enable && !ocActive
    && offsetReg == 3'h0 && hallS2 == 3'b011 && $stable(hallS2)
    |=> phaseDrive.lo == 3'b100 && (phaseDrive.hi & 3'b101) == 3'b000)
    else $error("Hall 011 did not drive B PWM and C low");
  AST_OFFSET: assert property (!sensorless && enable && !ocActive
    && offsetReg == 3'h5 && hallS2 == 3'b101
    |=> phaseDrive.lo == 3'b010)
    else $error("Offset of five did not select state five pattern");
  AST_HALL_BAD: assert property (!sensorless && (hallS2 == 3'b000 || hallS2 == 3'b111)
    |=> phaseDrive == '0)
    else $error("Invalid Hall code did not switch phases off");
  AST_TICK: assert property (tick && seenTick && $stable(pwmDiv) && pwmDiv != 16'h0000
    |-> sinceTick == pwmDiv)
    else $error("Commutation tick spacing differs from PWM period");
  AST_OC_TRIP: assert property (ocpEnable && ocS2 |=> ocActive ##1 phaseDrive == '0)
    else $error("Over-current did not latch and open all switches");
  AST_OC_CLEAR: assert property ($fell(ocActive) |-> $past(ocClrMs) != 16'h0000
    && $past(msElapsed) + 16'h0001 >= $past(ocClrMs))
    else $error("Over-current cleared before its time");
  AST_OC_STUCK: assert property (ocActive && ocClrMs == 16'h0000 |=> ocActive)
    else $error("Over-current cleared with zero clear time");
  AST_RAMP_START: assert property (mode == BCS_IDLE && enable && sensorless && !ocActive
    |=> mode == BCS_RAMP && interval == $past(rampInit) && stepCnt == 16'h0000
    && accCnt == 16'h0000)
    else $error("Ramp did not start from its initial values");
  AST_RAMP_END: assert property (mode == BCS_RUN && $past(mode) == BCS_RAMP
    |-> $past(interval) <= $past(rampFinal))
    else $error("Ramp ended before reaching final step length");
  AST_DISABLED: assert property (!enable |=> phaseDrive == '0)
    else $error("Phases driven while disabled");

  COV_RAMP_RUN: cover property (mode == BCS_RAMP ##1 mode == BCS_RUN);
  COV_OC_CYCLE: cover property ($rose(ocActive) ##[1:1000] $fell(ocActive));
  COV_BEMF_STEP: cover property (mode == BCS_RUN && tick && bemfEdge);
endmodule
`default_nettype wire

// file: dv/bcs_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_motor_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] pos,
  input  wire logic       spin,
  output var  logic [2:0] hall,
  output var  logic [2:0] bemf
);
  // Index 6 and 7 give the two codes a real sensor set never shows
  localparam logic [23:0] CODES = {3'h7, 3'h0, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  logic [4:0] cnt  = 5'h00;
  logic       lvl  = 1'b0;
  assign hall = CODES[pos*3 +: 3];
  // Period of 23 cycles keeps the flips out of step with the 16-cycle tick
  always @(posedge clk_sys) begin
    if (spin) begin
      cnt <= (cnt == 5'h16) ? 5'h00 : cnt + 5'h01;
      if (cnt == 5'h16) begin
        lvl <= ~lvl;
      end
    end
  end
  assign bemf = {3{lvl}};
endmodule
`default_nettype wire

// file: dv/bcs_commutation_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"
module bcs_commutation_tb;
  import bcs_pkg::*;
  logic                clk_sys = 1'b0;
  logic                resetn  = 1'b0;
  logic                hsel    = 1'b0;
  logic [31:0]         haddr   = 32'h0;
  logic [1:0]          htrans  = 2'h0;
  logic                hwrite  = 1'b0;
  logic [2:0]          hsize   = 3'h2;
  logic [31:0]         hwdata  = 32'h0;
  logic                hreadyout;
  logic [31:0]         hrdata;
  logic                hresp;
  logic [2:0]          hall;
  logic [2:0]          bemf;
  logic                ocFault = 1'b0;
  logic [7:0]          spdDuty = 8'h00;
  logic [7:0]          curDuty = 8'h00;
  bcs_phase_t          phaseDrive;
  logic [23:0]         spdPer;
  logic [31:0]         spdNorm;
  logic [2:0]          pos     = 3'h0;
  logic                spin    = 1'b0;
  logic [31:0]         rdv;
  logic [2:0]          expLo;
  logic [2:0]          prev;
  int                  bad_count = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  int                  s, t0, cnt, chg;
  int                  LO [6] = '{1, 2, 2, 0, 0, 1};
  int                  HI [6] = '{0, 0, 1, 1, 2, 2};
  int                  PW [4] = '{8, 4, 4, 4};
  logic [7:0]          RA [9] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
  logic [31:0]         RV [9] = '{32'h4, 32'h2710, 32'h64, 32'h4, 32'hBB8, 32'h64, 32'h28,
                                  32'h64, 32'h0};
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  bcs_commutation #(.CLK_PER_MS(10)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hall(hall), .bemf(bemf),
    .ocFault(ocFault), .spdDuty(spdDuty), .curDuty(curDuty), .phaseDrive(phaseDrive),
    .speedPeriod(spdPer), .speedNorm(spdNorm)
  );
  bcs_motor_model i_motor (
    .clk_sys(clk_sys), .pos(pos), .spin(spin), .hall(hall), .bemf(bemf)
  );
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic waitRdy;
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      bad_count++;
      $display("unexpected at %0t: bus hang", $time);
      conclude();
    end
  endtask
  // Address phase held until ready, then data phase held until ready again
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic doReset;
    resetn <= 1'b0;
    tick(4);
    resetn <= 1'b1;
    tick(1);
  endtask
  initial begin
    tick(4);
    resetn <= 1'b1;
    tick(1);
    for (int k = 0; k < 9; k++) begin
      rd(RA[k]);
      chk(rdv, RV[k], "reset value");
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C);
    chk(rdv, 32'h0, "unmapped");
    chk(hresp, 1'b0, "response");
    $display("test registers done");
    wr(`BCS_OFF_PWMDIV, 32'h10);
    spdDuty <= 8'hFF;
    wr(`BCS_OFF_CTRL, 32'h5);
    for (int o = 0; o < 6; o += 5) begin
      wr(`BCS_OFF_OFFSET, o);
      for (int h = 0; h < 8; h++) begin
        pos <= h[2:0];
        tick(6);
        s = (h + o) % 6;
        expLo = (h > 5) ? 3'h0 : 3'(3'h1 << LO[s]);
        chk(phaseDrive.lo, expLo, "low side");
        chk(phaseDrive.hi & ~((h > 5) ? 3'h0 : 3'(3'h1 << HI[s])), 3'h0, "high side");
        rd(`BCS_OFF_STATUS);
        chk(rdv[2:0], (h > 5) ? 3'h7 : 3'(s), "state");
      end
    end
    $display("test hall done");
    wr(`BCS_OFF_OFFSET, 32'h0);
    pos <= 3'h0;
    spdDuty <= 8'h80;
    curDuty <= 8'h40;
    for (int d = 0; d < 4; d++) begin
      wr(`BCS_OFF_CTRL, (d << 4) | 5);
      tick(20);
      cnt = 0;
      repeat (16) begin
        @(negedge clk_sys);
        cnt += int'(phaseDrive.hi[0]);
      end
      chk(cnt, PW[d], "pwm width");
    end
    wr(`BCS_OFF_CTRL, 32'h4);
    tick(3);
    chk(phaseDrive, 6'h00, "disabled off");
    $display("test pwm done");
    wr(`BCS_OFF_OCCLR, 32'h2);
    wr(`BCS_OFF_CTRL, 32'h5);
    ocFault <= 1'b1;
    tick(3);
    ocFault <= 1'b0;
    tick(3);
    chk(phaseDrive, 6'h00, "fault off");
    tick(5);
    rd(`BCS_OFF_STATUS);
    chk(rdv[3], 1'b1, "fault held");
    tick(25);
    rd(`BCS_OFF_STATUS);
    chk(rdv[3], 1'b0, "fault cleared");
    chk(phaseDrive.lo, 3'h2, "drive resumed");
    wr(`BCS_OFF_OCCLR, 32'h0);
    ocFault <= 1'b1;
    tick(3);
    ocFault <= 1'b0;
    tick(80);
    rd(`BCS_OFF_STATUS);
    chk(rdv[3], 1'b1, "fault latched");
    chk(phaseDrive, 6'h00, "latched off");
    doReset();
    rd(`BCS_OFF_STATUS);
    chk(rdv[3], 1'b0, "fault after reset");
    wr(`BCS_OFF_PWMDIV, 32'h10);
    wr(`BCS_OFF_CTRL, 32'h1);
    ocFault <= 1'b1;
    tick(8);
    chk(phaseDrive.lo, 3'h2, "protection off");
    ocFault <= 1'b0;
    $display("test overcurrent done");
    wr(`BCS_OFF_RINIT, 32'h6);
    wr(`BCS_OFF_RFINAL, 32'h4);
    wr(`BCS_OFF_RACC, 32'h3);
    wr(`BCS_OFF_CTRL, 32'h7);
    t0 = cyc;
    tick(1);
    rd(`BCS_OFF_STATUS);
    chk(rdv[5:4], 2'h1, "ramp mode");
    chk(rdv[21:6], 16'h6, "ramp start");
    chg = 0;
    prev = rdv[2:0];
    for (int i = 0; i < 100 && rdv[5:4] != 2'h2; i++) begin
      rd(`BCS_OFF_STATUS);
      chg += (rdv[5:4] == 2'h1 && rdv[2:0] != prev) ? 1 : 0;
      prev = rdv[2:0];
    end
    chk(rdv[5:4], 2'h2, "run mode");
    chk(rdv[21:6], 16'h4, "ramp end");
    chk(cyc - t0 >= 90 && cyc - t0 <= 150, 1'b1, "ramp time");
    chk(chg > 0, 1'b1, "open loop steps");
    prev = rdv[2:0];
    tick(100);
    rd(`BCS_OFF_STATUS);
    chk(rdv[2:0], prev, "still rotor");
    spin <= 1'b1;
    tick(100);
    rd(`BCS_OFF_STATUS);
    chk(rdv[2:0] != prev, 1'b1, "emf steps");
    spin <= 1'b0;
    wr(`BCS_OFF_CTRL, 32'h1);
    wr(`BCS_OFF_CTRL, 32'h7);
    tick(1);
    rd(`BCS_OFF_STATUS);
    chk(rdv[21:6], 16'h6, "ramp restart");
    chk(rdv[5:4], 2'h1, "ramp again");
    $display("test sensorless done");
    wr(`BCS_OFF_POLES, 32'h3);
    wr(`BCS_OFF_RATED, 32'h200);
    for (int m = 0; m < 2; m++) begin
      wr(`BCS_OFF_CTRL, (m == 0) ? 32'h1 : 32'hB);
      repeat (3) begin
        for (int p = 0; p < 6; p++) begin
          pos <= p[2:0];
          tick(32);
        end
      end
      rd(`BCS_OFF_PERIOD);
      chk(rdv == 32'd33 || rdv == 32'd36, 1'b1, "turn period");
      chk(spdPer, rdv[23:0], "period output");
      t0 = rdv;
      rd(`BCS_OFF_NORM);
      chk(rdv, 2 * t0, "normalised speed");
      chk(spdNorm, rdv, "norm output");
    end
    $display("test speed done");
    conclude();
  end
endmodule
`default_nettype wire
